/* hdl/oad_operand_decode.sv */
// Purpose: Operand addressing and format decode for an 8-bit RISC core.
// Assumes: One clock, synchronous active-high reset, Avalon-MM slave.
// Notes: Each accepted command word is decoded in one clock cycle.
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Carry out of a pointer low byte increments its high byte.
// - Borrow out of a pointer low byte decrements its high byte.
// - Direct special mode uses seven locator bits, 127 locations.
// - Locator bit 7 separates global from special direct access.
// - All-zero locator uses 12-bit indirect pointer, top nibble ignored.
// - Locator bit 8 adds a 7-bit unsigned offset to 12-bit base.
// - Offset mode, bit 7 clear, bases on data pointer.
// - Offset mode, bit 7 set, bases on software stack pointer.
// - Push and pop move one byte; stack grows downward.
// - Pop operand uses old pointer, stack slot uses new pointer.
// - Software stack is separate from the call and return stack.
// - Instructions are one 32-bit command word, each decoded in one cycle.
// - Two-operand result goes to W on D zero, operand on one.
// - Multiply ignores D; high byte to product register, low to W.
// - Single-operand D zero writes W, D one writes operand back.
// - Immediate format carries 8-bit literal for W, stack or special.
// - Jump target is page bits above 13 instruction bits.
// - Bit operations pick one of eight bits by 3-bit field.
// - The operand locator is a 9-bit mode and address field.
// - Direct global address is 0x080 plus the low field bits.
module oad_operand_decode
   import oad_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output oad_dec_s dec_out
);

   oad_state_s st_r;
   oad_state_s st_nxt;

   // Merges write data into a word under the byte enables.
   function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            v[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return v;
   endfunction

   // Keeps the twelve address bits of a pointer pair.
   function automatic logic [11:0] base12(input logic [15:0] p);
      return p[11:0];
   endfunction

   // Adds or subtracts on the low byte and ripples into the high byte.
   function automatic logic [15:0] ptr_adj(input logic [15:0] p,
      input logic [7:0] amt, input logic sub);
      logic [8:0] lo;
      logic [7:0] hi;
      lo = sub ? ({1'b0, p[7:0]} - {1'b0, amt})
               : ({1'b0, p[7:0]} + {1'b0, amt});
      hi = sub ? (p[15:8] - {7'h0, lo[8]}) : (p[15:8] + {7'h0, lo[8]});
      return {hi, lo[7:0]};
   endfunction

   // Returns the word seen by a read of the given offset.
   function automatic logic [31:0] reg_read(input logic [7:0] a,
      input oad_state_s s);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         OFS_INSTR: v = s.cmd;
         OFS_IPTR: v = {16'h0000, s.ind_ptr};
         OFS_DPTR: v = {16'h0000, s.data_ptr};
         OFS_SPTR: v = {16'h0000, s.soft_stack_ptr};
         OFS_XPTR: v = {16'h0000, s.external_addr};
         OFS_PAGE: v = {29'h0000_0000, s.page_select_bits};
         OFS_RES_EA: v = {8'h00, s.dec.stk_ea, s.dec.ea};
         OFS_RES_AUX: v = {5'h00, s.dec.bit_sel, s.dec.lit, s.dec.target};
         OFS_RES_FLAG: v = {22'h00_0000, s.dec.valid, s.dec.rd_opnd,
            s.dec.rd_work, s.dec.wr_opnd, s.dec.wr_work, s.dec.wr_prodh,
            s.dec.rd_stack, s.dec.wr_stack, s.dec.wr_sreg, s.dec.low_hit};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Next-state logic: bus slave, pointer adjust and decode.
   always_comb begin
      logic [31:0] m;
      logic [8:0] loc;
      logic dbit;
      logic ptr_mode;
      logic [11:0] base;
      logic [15:0] sp_new;
      oad_dec_s d;
      m = 32'h0000_0000;
      loc = st_r.cmd[8:0];
      dbit = st_r.cmd[DBIT_POS];
      ptr_mode = 1'b0;
      base = 12'h000;
      sp_new = st_r.soft_stack_ptr;
      d = '0;
      st_nxt = st_r;
      st_nxt.go = 1'b0;
      st_nxt.dec.valid = 1'b0;

      // Decode the command word latched on the previous cycle.
      if (st_r.go) begin
         if (loc == 9'h000) begin
            d.ea = base12(st_r.ind_ptr);
            ptr_mode = 1'b1;
         end else if (!loc[LOC_MODE]) begin
            if (!loc[LOC_SEL]) begin
               d.ea = {5'h00, loc[6:0]};
            end else begin
               d.ea = GLOBAL_BASE + {5'h00, loc[6:0]};
            end
         end else begin
            base = loc[LOC_SEL] ? base12(st_r.soft_stack_ptr)
                                : base12(st_r.data_ptr);
            d.ea = base + {5'h00, loc[6:0]};
            ptr_mode = 1'b1;
         end
         d.low_hit = ptr_mode && (d.ea < LOW_LIMIT);
         d.valid = 1'b1;
         case (oad_opk_e'(st_r.cmd[OPK_LSB +: 3]))
            OPK_TWO: begin
               d.rd_opnd = 1'b1;
               d.rd_work = 1'b1;
               d.wr_work = !dbit;
               d.wr_opnd = dbit;
            end
            OPK_SINGLE: begin
               d.rd_opnd = 1'b1;
               d.wr_work = !dbit;
               d.wr_opnd = dbit;
            end
            OPK_MUL: begin
               d.rd_opnd = 1'b1;
               d.rd_work = 1'b1;
               d.wr_work = 1'b1;
               d.wr_prodh = 1'b1;
            end
            OPK_IMM: begin
               d.lit = st_r.cmd[7:0];
               d.ea = 12'h000;
               d.low_hit = 1'b0;
               case (oad_immt_e'(st_r.cmd[IMMT_LSB +: 2]))
                  IMMT_WORK: d.wr_work = 1'b1;
                  IMMT_STACK: begin
                     d.wr_stack = 1'b1;
                     d.stk_ea = base12(st_r.soft_stack_ptr);
                  end
                  IMMT_SREG: begin
                     d.wr_sreg = 1'b1;
                     d.ea = {5'h00, st_r.cmd[SREG_LSB +: 7]};
                  end
                  default: d.wr_work = 1'b0;
               endcase
            end
            OPK_JUMP: begin
               d.target = {st_r.page_select_bits, st_r.cmd[12:0]};
               d.ea = 12'h000;
               d.low_hit = 1'b0;
            end
            OPK_BIT: begin
               d.bit_sel = st_r.cmd[BSEL_LSB +: 3];
               d.rd_opnd = 1'b1;
               d.wr_opnd = 1'b1;
            end
            OPK_PUSH: begin
               // store at top, then move down
               d.rd_opnd = 1'b1;
               d.wr_stack = 1'b1;
               d.stk_ea = base12(st_r.soft_stack_ptr);
               st_nxt.soft_stack_ptr =
                  ptr_adj(st_r.soft_stack_ptr, 8'h01, 1'b1);
            end
            OPK_POP: begin
               sp_new = ptr_adj(st_r.soft_stack_ptr, 8'h01, 1'b0);
               d.rd_stack = 1'b1;
               d.wr_opnd = 1'b1;
               d.stk_ea = base12(sp_new);
               st_nxt.soft_stack_ptr = sp_new;
            end
            default: d.valid = 1'b1;
         endcase
         st_nxt.dec = d;
      end

      // Bus slave: one wait cycle, then the access completes.
      if (avs_read_in || avs_write_in) begin
         if (st_r.waitreq) begin
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata = reg_read(avs_address_in, st_r);
         end else begin
            st_nxt.waitreq = 1'b1;
            if (avs_write_in) begin
               m = be_merge(reg_read(avs_address_in, st_r),
                  avs_writedata_in, avs_byteenable_in);
               case (avs_address_in)
                  OFS_INSTR: begin
                     st_nxt.cmd = m;
                     st_nxt.go = 1'b1;
                  end
                  OFS_IPTR: st_nxt.ind_ptr = m[15:0];
                  OFS_DPTR: st_nxt.data_ptr = m[15:0];
                  OFS_SPTR: st_nxt.soft_stack_ptr = m[15:0];
                  OFS_XPTR: st_nxt.external_addr = m[15:0];
                  OFS_PAGE: st_nxt.page_select_bits = m[2:0];
                  OFS_ADJ: begin
                     case (oad_psel_e'(m[ADJ_SEL_LSB +: 2]))
                        PSEL_IND: st_nxt.ind_ptr = ptr_adj(
                           st_r.ind_ptr, m[7:0], m[ADJ_SUB_POS]);
                        PSEL_DATA: st_nxt.data_ptr = ptr_adj(
                           st_r.data_ptr, m[7:0], m[ADJ_SUB_POS]);
                        PSEL_STACK: st_nxt.soft_stack_ptr = ptr_adj(
                           st_r.soft_stack_ptr, m[7:0], m[ADJ_SUB_POS]);
                        default: st_nxt.external_addr = ptr_adj(
                           st_r.external_addr, m[7:0], m[ADJ_SUB_POS]);
                     endcase
                  end
                  default: st_nxt.go = 1'b0;
               endcase
            end
         end
      end else begin
         st_nxt.waitreq = 1'b1;
      end
   end

   // State register; the software stack pointer has no link to calls.
   // independent software stack
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_r <= '0;
         st_r.waitreq <= 1'b1;
         st_r.cmd <= CMD_RST;
         st_r.ind_ptr <= PTR_RST;
         st_r.data_ptr <= PTR_RST;
         st_r.soft_stack_ptr <= PTR_RST;
         st_r.external_addr <= PTR_RST;
         st_r.page_select_bits <= PAGE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register.
   assign avs_readdata_out = st_r.rdata;
   assign avs_waitrequest_out = st_r.waitreq;
   assign dec_out = st_r.dec;

   // Helper terms for the checks below.
   logic bus_take;
   logic adj_full;
   logic [8:0] c_loc;
   logic [2:0] c_opk;
   assign bus_take = (avs_read_in || avs_write_in) && !st_r.waitreq;
   assign adj_full = bus_take && avs_write_in &&
      (avs_address_in == OFS_ADJ) && (avs_byteenable_in == 4'hf);
   assign c_loc = st_r.cmd[8:0];
   assign c_opk = st_r.cmd[OPK_LSB +: 3];

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_instr_taken;
      bus_take && avs_write_in && (avs_address_in == OFS_INSTR);
   endsequence

   sequence s_pop_go;
      st_r.go && (c_opk == OPK_POP) && (c_loc[8:7] == 2'b11);
   endsequence

   a_bus_answer: assert property (
      (avs_read_in || avs_write_in) && st_r.waitreq |=> !st_r.waitreq)
      else $error("waitrequest did not drop after one cycle");
   a_instr_rate: assert property (
      s_instr_taken ##1 st_r.go |=> st_r.dec.valid)
      else $error("decode not produced one cycle after command");
   a_carry_high: assert property (
      adj_full && !avs_writedata_in[ADJ_SUB_POS] &&
      (avs_writedata_in[17:16] == PSEL_DATA) &&
      ({1'b0, st_r.data_ptr[7:0]} + {1'b0, avs_writedata_in[7:0]}
         > 9'h0ff)
      |=> st_r.data_ptr[15:8] == $past(st_r.data_ptr[15:8]) + 8'h01)
      else $error("carry not propagated into pointer high byte");
   a_borrow_high: assert property (
      adj_full && avs_writedata_in[ADJ_SUB_POS] &&
      (avs_writedata_in[17:16] == PSEL_STACK) &&
      (st_r.soft_stack_ptr[7:0] < avs_writedata_in[7:0])
      |=> st_r.soft_stack_ptr[15:8] ==
         $past(st_r.soft_stack_ptr[15:8]) - 8'h01)
      else $error("borrow not propagated into pointer high byte");
   a_direct_sreg: assert property (
      st_r.go && (c_opk == OPK_TWO) && (c_loc[8:7] == 2'b00) &&
      (c_loc != 9'h000) |=> st_r.dec.ea == {5'h00, $past(c_loc[6:0])})
      else $error("special register address wrong");
   a_direct_glob: assert property (
      st_r.go && (c_opk == OPK_TWO) && (c_loc[8:7] == 2'b01)
      |=> st_r.dec.ea == 12'h080 + {5'h00, $past(c_loc[6:0])})
      else $error("global register address wrong");
   a_indirect_ea: assert property (
      st_r.go && (c_opk inside {OPK_TWO, OPK_SINGLE}) && (c_loc == 9'h000)
      |=> st_r.dec.ea == $past(st_r.ind_ptr[11:0]))
      else $error("indirect address wrong");
   a_offset_dp: assert property (
      st_r.go && (c_opk == OPK_TWO) && (c_loc[8:7] == 2'b10)
      |=> st_r.dec.ea ==
         $past(st_r.data_ptr[11:0]) + {5'h00, $past(c_loc[6:0])})
      else $error("data pointer offset address wrong");
   a_offset_sp: assert property (
      st_r.go && (c_opk == OPK_TWO) && (c_loc[8:7] == 2'b11)
      |=> st_r.dec.ea ==
         $past(st_r.soft_stack_ptr[11:0]) + {5'h00, $past(c_loc[6:0])})
      else $error("stack pointer offset address wrong");
   a_bit_select: assert property (
      st_r.go && (c_opk == OPK_BIT) |=> st_r.dec.bit_sel ==
         $past(st_r.cmd[BSEL_LSB +: 3]))
      else $error("bit select wrong");
   a_pop_order: assert property (
      s_pop_go |=> (st_r.dec.ea == $past(st_r.soft_stack_ptr[11:0])
         + {5'h00, $past(c_loc[6:0])}) &&
         (st_r.dec.stk_ea == st_r.soft_stack_ptr[11:0]))
      else $error("pop address order wrong");
   a_push_down: assert property (
      st_r.go && (c_opk == OPK_PUSH) |=> st_r.soft_stack_ptr ==
         $past(st_r.soft_stack_ptr) - 16'h0001)
      else $error("push did not move stack downward");
   a_dbit_dest: assert property (
      st_r.go && (c_opk == OPK_TWO) |=>
         (st_r.dec.wr_opnd == $past(st_r.cmd[DBIT_POS])) &&
         (st_r.dec.wr_work != st_r.dec.wr_opnd))
      else $error("two-operand destination wrong");
   a_mul_split: assert property (
      st_r.go && (c_opk == OPK_MUL) |=> st_r.dec.wr_prodh &&
         st_r.dec.wr_work && !st_r.dec.wr_opnd)
      else $error("multiply destinations wrong");
   a_jump_page: assert property (
      st_r.go && (c_opk == OPK_JUMP) |=> st_r.dec.target ==
         {$past(st_r.page_select_bits), $past(st_r.cmd[12:0])})
      else $error("jump target wrong");

endmodule
`default_nettype wire

/* inc/oad_pkg.sv */
// Purpose: Shared constants and types for the operand address decoder.
// Assumes: Registers sit on aligned 32-bit words of an Avalon-MM slave.
// Notes: Pointer words keep the high byte in bits 15:8.
`default_nettype none
package oad_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_IPTR = 8'h04;
   localparam logic [7:0] OFS_DPTR = 8'h08;
   localparam logic [7:0] OFS_SPTR = 8'h0c;
   localparam logic [7:0] OFS_XPTR = 8'h10;
   localparam logic [7:0] OFS_PAGE = 8'h14;
   localparam logic [7:0] OFS_ADJ = 8'h18;
   localparam logic [7:0] OFS_RES_EA = 8'h1c;
   localparam logic [7:0] OFS_RES_AUX = 8'h20;
   localparam logic [7:0] OFS_RES_FLAG = 8'h24;

   // Field positions inside the command word and the adjust register word.
   localparam int LOC_MODE = 8;
   localparam int LOC_SEL = 7;
   localparam int DBIT_POS = 9;
   localparam int BSEL_LSB = 9;
   localparam int OPK_LSB = 16;
   localparam int IMMT_LSB = 19;
   localparam int SREG_LSB = 21;
   localparam int ADJ_SEL_LSB = 16;
   localparam int ADJ_SUB_POS = 18;

   // Address constants and reset values.
   localparam logic [11:0] GLOBAL_BASE = 12'h080;
   localparam logic [11:0] LOW_LIMIT = 12'h020;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [2:0] PAGE_RST = 3'h0;
   localparam logic [31:0] CMD_RST = 32'h0000_0000;

   // Instruction formats handed to the decoder.
   typedef enum logic [2:0] {
      OPK_TWO = 3'h0,
      OPK_SINGLE = 3'h1,
      OPK_IMM = 3'h2,
      OPK_MUL = 3'h3,
      OPK_POP = 3'h4,
      OPK_PUSH = 3'h5,
      OPK_JUMP = 3'h6,
      OPK_BIT = 3'h7
   } oad_opk_e;

   // Destination of an immediate-format literal.
   typedef enum logic [1:0] {
      IMMT_WORK = 2'h0,
      IMMT_STACK = 2'h1,
      IMMT_SREG = 2'h2,
      IMMT_NONE = 2'h3
   } oad_immt_e;

   // Pointer selector of the adjust register.
   typedef enum logic [1:0] {
      PSEL_IND = 2'h0,
      PSEL_DATA = 2'h1,
      PSEL_STACK = 2'h2,
      PSEL_EXT = 2'h3
   } oad_psel_e;

   // Decoded result of one instruction.
   typedef struct packed {
      logic valid;
      logic rd_opnd;
      logic rd_work;
      logic wr_opnd;
      logic wr_work;
      logic wr_prodh;
      logic rd_stack;
      logic wr_stack;
      logic wr_sreg;
      logic low_hit;
      logic [2:0] bit_sel;
      logic [7:0] lit;
      logic [15:0] target;
      logic [11:0] stk_ea;
      logic [11:0] ea;
   } oad_dec_s;

   // Whole state of the decoder.
   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic [15:0] ind_ptr;
      logic [15:0] data_ptr;
      logic [15:0] soft_stack_ptr;
      logic [15:0] external_addr;
      logic [2:0] page_select_bits;
      logic go;
      logic [31:0] cmd;
      oad_dec_s dec;
   } oad_state_s;
endpackage
`default_nettype wire

/* bench/oad_mem_model.sv */
// Purpose: Far-side model of data memory taking each decoded access.
// Assumes: dec_in.valid is a one-cycle pulse on the core clock.
// Notes: Keeps the last access, counts accesses and low pointer hits.
`timescale 1ns/1ps
`default_nettype none
module oad_mem_model
   import oad_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire oad_dec_s dec_in,
   output oad_dec_s last_out,
   output logic [15:0] count_out,
   output logic [15:0] low_count_out
);
   // Each valid pulse is one access that the memory acts on.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         last_out <= '0;
         count_out <= 16'h0000;
         low_count_out <= 16'h0000;
      end else if (dec_in.valid) begin
         last_out <= dec_in;
         count_out <= count_out + 16'h0001;
         if (dec_in.low_hit) begin
            low_count_out <= low_count_out + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: Self-checking bench for the operand address decoder.
// Assumes: One wait cycle per bus access, decode after a command write.
// Notes: Byte enables stay all ones; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module tb
   import oad_pkg::*;
   ;
   logic ref_clk_in;
   logic rst_in;
   logic [7:0] avs_address_in;
   logic avs_read_in;
   logic avs_write_in;
   logic [31:0] avs_writedata_in;
   logic [3:0] avs_byteenable_in;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   oad_dec_s dec_w;
   oad_dec_s last;
   logic [15:0] cnt;
   logic [15:0] low_cnt;
   logic [31:0] rd;
   int miscompares = 0;
   int samples_checked = 0;

   oad_operand_decode u_dut (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .dec_out(dec_w)
   );

   oad_mem_model u_mem (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .dec_in(dec_w),
      .last_out(last),
      .count_out(cnt),
      .low_count_out(low_cnt)
   );

   // The core clock toggles every 10 ns, a period of 20 ns.
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic give_verdict();
      $display("Compared %0d, mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // A wait that ran out ends the run as a mismatch.
   task automatic timed_out();
      miscompares++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      give_verdict();
   endtask

   // Compares one value against its expectation.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask

   // One bus access held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      rd = avs_readdata_out;
      if (n >= 50) timed_out();
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask

   // Builds a command word from format and low field.
   function automatic logic [31:0] cmd(input oad_opk_e k,
                                       input logic [15:0] lo);
      return {13'h0, k, lo};
   endfunction

   // Sends one command and waits for the memory to take it.
   task automatic dec(input logic [31:0] c);
      logic [15:0] c0;
      int n;
      c0 = cnt;
      n = 0;
      bus(1'b1, OFS_INSTR, c);
      while (cnt === c0 && n < 20) begin
         @(posedge ref_clk_in);
         n++;
      end
      if (n >= 20) timed_out();
      repeat (2) @(posedge ref_clk_in);
      chk(32'(cnt), 32'(c0) + 32'h1, "one decode per word");
   endtask

   // Reset leaves the decode address, the data pointer and the page clear.
   task automatic t_reset();
      chk(32'(dec_w.ea), 32'h0, "decode after reset");
      bus(1'b0, OFS_DPTR, 32'h0);
      chk(rd, 32'h0, "pointer after reset");
      bus(1'b0, OFS_PAGE, 32'h0);
      chk(rd, 32'h0, "page after reset");
   endtask

   // Direct special and global modes over their edge values.
   task automatic t_direct();
      logic [8:0] loc [5] = '{9'h001, 9'h012, 9'h07f, 9'h080, 9'h0ff};
      logic [11:0] e;
      for (int i = 0; i < 5; i++) begin
         dec(cmd(OPK_TWO, {7'h0, loc[i]}));
         e = loc[i][7] ? GLOBAL_BASE + 12'(loc[i][6:0]) : 12'(loc[i][6:0]);
         chk(32'(last.ea), 32'(e), "direct address");
      end
   endtask

   // All-zero locator goes through the indirect pointer.
   task automatic t_indirect();
      bus(1'b1, OFS_IPTR, 32'h0000_f385);
      dec(cmd(OPK_TWO, 16'h0000));
      chk(32'(last.ea), 32'h385, "indirect address");
      dec(cmd(OPK_SINGLE, 16'h0000));
      chk(32'(last.ea), 32'h385, "indirect single");
   endtask

   // Offset modes pick the base by locator bit 7.
   task automatic t_offset();
      logic [8:0] loc [4] = '{9'h108, 9'h17f, 9'h180, 9'h1ff};
      logic [11:0] e;
      bus(1'b1, OFS_DPTR, 32'h0000_f385);
      bus(1'b1, OFS_SPTR, 32'h0000_a200);
      for (int i = 0; i < 4; i++) begin
         dec(cmd(OPK_TWO, {7'h0, loc[i]}));
         e = (loc[i][7] ? 12'h200 : 12'h385) + 12'(loc[i][6:0]);
         chk(32'(last.ea), 32'(e), "offset address");
      end
   endtask

   // Carry crosses into the high byte of the indirect and data pointers, borrow into that of the stack and external pointers.
   task automatic t_adjust();
      logic [15:0] st [4] = '{16'h02ff, 16'h00ff, 16'h0100, 16'h0310};
      logic [7:0] amt [4] = '{8'h01, 8'h01, 8'h01, 8'h20};
      logic sb [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
      logic [15:0] e;
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OFS_IPTR + 8'(4 * i), {16'h0, st[i]});
         bus(1'b1, OFS_ADJ, {13'h0, sb[i], 2'(i), 8'h0, amt[i]});
         bus(1'b0, OFS_IPTR + 8'(4 * i), 32'h0);
         e = sb[i] ? st[i] - 16'(amt[i]) : st[i] + 16'(amt[i]);
         chk(rd, {16'h0, e}, "pointer adjust");
      end
   endtask

   // Push grows the stack down; pop uses the old pointer for its operand.
   task automatic t_stack();
      bus(1'b1, OFS_SPTR, 32'h0000_0200);
      dec(cmd(OPK_PUSH, 16'h0085));
      chk(32'(last.stk_ea), 32'h200, "push slot");
      bus(1'b0, OFS_SPTR, 32'h0);
      chk(rd, 32'h0000_01ff, "pointer after push");
      dec(cmd(OPK_POP, 16'h0182));
      chk(32'(last.ea), 32'h201, "pop operand");
      chk(32'(last.stk_ea), 32'h200, "pop slot");
      bus(1'b0, OFS_SPTR, 32'h0);
      chk(rd, 32'h0000_0200, "pointer after pop");
   endtask

   // Destination by D bit for two-operand, single and multiply.
   task automatic t_dest();
      oad_opk_e k [6] = '{OPK_TWO, OPK_TWO, OPK_SINGLE, OPK_SINGLE,
                          OPK_MUL, OPK_MUL};
      logic [3:0] e [6] = '{4'ha, 4'hc, 4'ha, 4'hc, 4'hb, 4'hb};
      for (int i = 0; i < 6; i++) begin
         dec(cmd(k[i], {6'h0, 1'(i % 2), 9'h085}));
         chk({28'h0, last.rd_opnd, last.wr_opnd, last.wr_work,
              last.wr_prodh}, 32'(e[i]), "destination");
      end
   endtask

   // Literal reaches work, stack or special register.
   task automatic t_imm();
      for (int t = 0; t < 3; t++) begin
         dec(cmd(OPK_IMM, 16'h00a5) | (32'(t) << IMMT_LSB) |
             (32'h13 << SREG_LSB));
         chk(32'(last.lit), 32'ha5, "literal");
         chk({29'h0, last.wr_work, last.wr_stack, last.wr_sreg},
             32'h4 >> t, "literal target");
         chk(32'(last.ea), (t == 2) ? 32'h13 : 32'h0, "literal ea");
      end
   endtask

   // Jump target is page bits above thirteen instruction bits.
   task automatic t_jump();
      logic [2:0] pg [2] = '{3'h5, 3'h7};
      logic [12:0] ad [2] = '{13'h1abc, 13'h1fff};
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, OFS_PAGE, {29'h0, pg[i]});
         bus(1'b0, OFS_PAGE, 32'h0);
         chk(rd, {29'h0, pg[i]}, "page readback");
         dec(cmd(OPK_JUMP, {3'h0, ad[i]}));
         chk(32'(last.target), {16'h0, pg[i], ad[i]}, "target");
      end
   endtask

   // Every bit select value reaches the decode.
   task automatic t_bit();
      for (int b = 0; b < 8; b++) begin
         dec(cmd(OPK_BIT, {4'h0, 3'(b), 9'h085}));
         chk(32'(last.bit_sel), 32'(b), "bit select");
      end
   endtask

   // Unmapped and write-only places read zero; stray writes are ignored.
   task automatic t_refuse();
      bus(1'b1, OFS_DPTR, 32'h0000_1234);
      bus(1'b1, 8'h30, 32'hffff_ffff);
      bus(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      bus(1'b0, OFS_ADJ, 32'h0);
      chk(rd, 32'h0, "adjust read");
      bus(1'b0, OFS_DPTR, 32'h0);
      chk(rd, 32'h0000_1234, "pointer kept");
   endtask

   // Main sequence: reset, then each scenario in turn.
   initial begin
      rst_in = 1'b1;
      avs_address_in = 8'h00;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'hf;
      repeat (4) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_direct();
      t_indirect();
      t_offset();
      t_adjust();
      t_stack();
      t_dest();
      t_imm();
      t_jump();
      t_bit();
      t_refuse();
      chk(32'(low_cnt), 32'h0, "low pointer hits");
      give_verdict();
   end
endmodule
`default_nettype wire
